/* File: lccr_pkg.sv */
package lccr_pkg;

  // byte register offsets on the management side
  localparam logic [7:0] IDLE_RATE_OFS = 8'h23;
  localparam logic [7:0] EQ_OFS = 8'h24;
  localparam logic [7:0] SWING_OFS = 8'h25;
  localparam logic [7:0] EMPH_OFS = 8'h26;
  localparam logic [7:0] THR_OFS = 8'h27;
  localparam logic [7:0] NEXT_IDLE_RATE_OFS = 8'h2B;

  // reset values
  localparam logic [7:0] IDLE_RATE_RST = 8'h00;
  localparam logic [7:0] EQ_RST = 8'h20;
  localparam logic [7:0] SWING_RST = 8'h03;
  localparam logic [7:0] EMPH_RST = 8'h03;
  localparam logic [7:0] THR_RST = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // writable bit masks; reserved bits are kept at zero
  localparam logic [7:0] IDLE_RATE_MASK = 8'h33;
  localparam logic [7:0] EQ_MASK = 8'h3F;
  localparam logic [7:0] SWING_MASK = 8'h3F;
  localparam logic [7:0] EMPH_MASK = 8'hFF;
  localparam logic [7:0] THR_MASK = 8'h0F;

  // idle/rate select bit positions
  localparam int IR_AUTO_IDLE = 5;
  localparam int IR_MUTE_SEL = 4;
  localparam int IR_AUTO_RATE = 1;
  localparam int IR_RATE_SEL = 0;

  // equalizer field positions
  localparam int EQ_EN_BIT = 5;
  localparam int EQ_GAIN_HI = 4;
  localparam int EQ_GAIN_LO = 3;
  localparam int EQ_BOOST_HI = 2;

  // emphasis and threshold field positions
  localparam int EMPH_TYPE_BIT = 7;
  localparam int EMPH_LEVEL_HI = 6;
  localparam int THR_DEASSERT_HI = 3;
  localparam int THR_DEASSERT_LO = 2;
  localparam int THR_ASSERT_HI = 1;

  // equalizer codes reachable from the straps
  localparam logic [5:0] EQ_BYPASS = 6'h20;
  localparam logic [5:0] EQ_C2A = 6'h2A;
  localparam logic [5:0] EQ_C30 = 6'h30;
  localparam logic [5:0] EQ_C31 = 6'h31;
  localparam logic [5:0] EQ_C38 = 6'h38;
  localparam logic [5:0] EQ_C34 = 6'h34;
  localparam logic [5:0] EQ_C35 = 6'h35;
  localparam logic [5:0] EQ_C3A = 6'h3A;
  localparam logic [5:0] EQ_C3C = 6'h3C;

  // emphasis codes reachable from the straps
  localparam logic [7:0] EMPH_0DB = 8'h01;
  localparam logic [7:0] EMPH_3P5DB = 8'h38;
  localparam logic [7:0] EMPH_6DB = 8'h88;
  localparam logic [7:0] EMPH_9DB = 8'h90;
  localparam logic [7:0] EMPH_12DB = 8'hA0;
  localparam logic [7:0] EMPH_RSVD = 8'hC0;

  // four-level strap reading
  typedef enum logic [1:0] {
    STRAP_LOW = 2'h0,
    STRAP_HIGH = 2'h1,
    STRAP_FLOAT = 2'h2,
    STRAP_SPARE = 2'h3
  } lccr_strap_t;

  // settings handed to the analog lane
  typedef struct packed {
    logic eq_enable;
    logic [1:0] gain_stage_field;
    logic [2:0] boost_step_field;
    logic [5:0] lane_output_swing_field;
    logic emphasis_type;
    logic [6:0] emphasis_level;
    logic [1:0] deassert_thr;
    logic [1:0] assert_thr;
    logic output_mute;
    logic auto_idle;
    logic auto_rate;
    logic rate_high;
  } lccr_lane_cfg_t;

  function automatic logic [5:0] strap_eq(input lccr_strap_t a,
                                          input lccr_strap_t b);
    logic [3:0] key;
    key = {a, b};
    case (key)
      {STRAP_FLOAT, STRAP_FLOAT}: strap_eq = EQ_BYPASS;
      {STRAP_HIGH, STRAP_HIGH}: strap_eq = EQ_C2A;
      {STRAP_LOW, STRAP_LOW}: strap_eq = EQ_C30;
      {STRAP_LOW, STRAP_FLOAT}: strap_eq = EQ_C31;
      {STRAP_LOW, STRAP_HIGH}: strap_eq = EQ_C38;
      {STRAP_HIGH, STRAP_FLOAT}: strap_eq = EQ_C34;
      {STRAP_HIGH, STRAP_LOW}: strap_eq = EQ_C35;
      {STRAP_FLOAT, STRAP_LOW}: strap_eq = EQ_C3A;
      {STRAP_FLOAT, STRAP_HIGH}: strap_eq = EQ_C3C;
      default: strap_eq = EQ_BYPASS;
    endcase
  endfunction

  // b is the first printed strap, a the second
  function automatic logic [7:0] strap_emph(input lccr_strap_t b,
                                            input lccr_strap_t a);
    logic [3:0] key;
    key = {b, a};
    case (key)
      {STRAP_LOW, STRAP_LOW}: strap_emph = EMPH_0DB;
      {STRAP_LOW, STRAP_HIGH}: strap_emph = EMPH_3P5DB;
      {STRAP_LOW, STRAP_FLOAT}: strap_emph = EMPH_6DB;
      {STRAP_HIGH, STRAP_LOW}: strap_emph = EMPH_9DB;
      {STRAP_HIGH, STRAP_FLOAT}: strap_emph = EMPH_12DB;
      {STRAP_FLOAT, STRAP_LOW}: strap_emph = EMPH_9DB;
      {STRAP_FLOAT, STRAP_HIGH}: strap_emph = EMPH_12DB;
      {STRAP_FLOAT, STRAP_FLOAT}: strap_emph = EMPH_RSVD;
      default: strap_emph = EMPH_0DB;
    endcase
  endfunction

endpackage

/* File: lccr_regs.sv */
`timescale 1ns/100ps

module lccr_regs (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_pin_mode,
  input wire lccr_pkg::lccr_strap_t i_rx_boost_strap_a,
  input wire lccr_pkg::lccr_strap_t i_rx_boost_strap_b,
  input wire lccr_pkg::lccr_strap_t i_tx_emphasis_strap_a,
  input wire lccr_pkg::lccr_strap_t i_tx_emphasis_strap_b,
  input wire logic i_signal_presence_detect,
  input wire logic i_rate_detect_high,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output lccr_pkg::lccr_lane_cfg_t o_cfg
);

  logic [7:0] idle_rate_reg;
  logic [7:0] idle_rate_next;
  logic [7:0] eq_reg;
  logic [7:0] eq_next;
  logic [7:0] swing_reg;
  logic [7:0] swing_next;
  logic [7:0] emph_reg;
  logic [7:0] emph_next;
  logic [7:0] thr_reg;
  logic [7:0] thr_next;
  logic [7:0] next_idle_rate_reg;
  logic [7:0] next_idle_rate_next;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  lccr_pkg::lccr_lane_cfg_t cfg_reg;
  lccr_pkg::lccr_lane_cfg_t cfg_next;
  logic [5:0] eq_src;
  logic [7:0] emph_src;

  // register writes; reserved bits masked so they always read zero
  always_comb
  begin
    idle_rate_next = idle_rate_reg;
    eq_next = eq_reg;
    swing_next = swing_reg;
    emph_next = emph_reg;
    thr_next = thr_reg;
    next_idle_rate_next = next_idle_rate_reg;
    if (i_wr_en)
    begin
      unique case (i_addr)
        lccr_pkg::IDLE_RATE_OFS:
          idle_rate_next = i_wr_data & lccr_pkg::IDLE_RATE_MASK;
        lccr_pkg::EQ_OFS:
          eq_next = i_wr_data & lccr_pkg::EQ_MASK;
        lccr_pkg::SWING_OFS:
          swing_next = i_wr_data & lccr_pkg::SWING_MASK;
        lccr_pkg::EMPH_OFS:
          emph_next = i_wr_data & lccr_pkg::EMPH_MASK;
        lccr_pkg::THR_OFS:
          thr_next = i_wr_data & lccr_pkg::THR_MASK;
        lccr_pkg::NEXT_IDLE_RATE_OFS:
          next_idle_rate_next = i_wr_data & lccr_pkg::IDLE_RATE_MASK;
        default:
        begin
          // unmapped writes are dropped
        end
      endcase
    end
  end

  // read port: one cycle latency, unmapped reads return zero
  always_comb
  begin
    rd_valid_next = i_rd_en;
    rd_data_next = rd_data_reg;
    if (i_rd_en)
    begin
      unique case (i_addr)
        lccr_pkg::IDLE_RATE_OFS: rd_data_next = idle_rate_reg;
        lccr_pkg::EQ_OFS: rd_data_next = eq_reg;
        lccr_pkg::SWING_OFS: rd_data_next = swing_reg;
        lccr_pkg::EMPH_OFS: rd_data_next = emph_reg;
        lccr_pkg::THR_OFS: rd_data_next = thr_reg;
        lccr_pkg::NEXT_IDLE_RATE_OFS: rd_data_next = next_idle_rate_reg;
        default: rd_data_next = lccr_pkg::READ_UNMAPPED;
      endcase
    end
  end

  // lane settings; straps override the equalizer and emphasis register values in pin mode
  always_comb
  begin
    eq_src = eq_reg[5:0];
    emph_src = emph_reg;
    if (i_pin_mode)
    begin
      eq_src = lccr_pkg::strap_eq(i_rx_boost_strap_a, i_rx_boost_strap_b);
      emph_src = lccr_pkg::strap_emph(i_tx_emphasis_strap_b,
                                      i_tx_emphasis_strap_a);
    end
    cfg_next.eq_enable = eq_src[lccr_pkg::EQ_EN_BIT];
    cfg_next.gain_stage_field =
      eq_src[lccr_pkg::EQ_GAIN_HI:lccr_pkg::EQ_GAIN_LO];
    cfg_next.boost_step_field = eq_src[lccr_pkg::EQ_BOOST_HI:0];
    cfg_next.lane_output_swing_field = swing_reg[5:0];
    cfg_next.emphasis_type = emph_src[lccr_pkg::EMPH_TYPE_BIT];
    cfg_next.emphasis_level = emph_src[lccr_pkg::EMPH_LEVEL_HI:0];
    cfg_next.deassert_thr =
      thr_reg[lccr_pkg::THR_DEASSERT_HI:lccr_pkg::THR_DEASSERT_LO];
    cfg_next.assert_thr = thr_reg[lccr_pkg::THR_ASSERT_HI:0];
    cfg_next.auto_idle = idle_rate_reg[lccr_pkg::IR_AUTO_IDLE];
    cfg_next.auto_rate = idle_rate_reg[lccr_pkg::IR_AUTO_RATE];
    if (idle_rate_reg[lccr_pkg::IR_AUTO_IDLE])
      cfg_next.output_mute = ~i_signal_presence_detect;
    else
      cfg_next.output_mute = idle_rate_reg[lccr_pkg::IR_MUTE_SEL];
    if (idle_rate_reg[lccr_pkg::IR_AUTO_RATE])
      cfg_next.rate_high = i_rate_detect_high;
    else
      cfg_next.rate_high = idle_rate_reg[lccr_pkg::IR_RATE_SEL];
  end

  // registers reset to their defaults and the lane settings to zero, never to a strap
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      idle_rate_reg <= lccr_pkg::IDLE_RATE_RST;
      eq_reg <= lccr_pkg::EQ_RST;
      swing_reg <= lccr_pkg::SWING_RST;
      emph_reg <= lccr_pkg::EMPH_RST;
      thr_reg <= lccr_pkg::THR_RST;
      next_idle_rate_reg <= lccr_pkg::IDLE_RATE_RST;
      rd_data_reg <= lccr_pkg::READ_UNMAPPED;
      rd_valid_reg <= 1'b0;
      cfg_reg <= '0;
    end
    else
    begin
      idle_rate_reg <= idle_rate_next;
      eq_reg <= eq_next;
      swing_reg <= swing_next;
      emph_reg <= emph_next;
      thr_reg <= thr_next;
      next_idle_rate_reg <= next_idle_rate_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      cfg_reg <= cfg_next;
    end
  end

  assign o_rd_data = rd_data_reg;
  assign o_rd_valid = rd_valid_reg;
  assign o_cfg = cfg_reg;

endmodule // lccr_regs

/* File: lccr_regs_sva.sv */
`timescale 1ns/100ps
module lccr_regs_sva (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_pin_mode,
  input wire lccr_pkg::lccr_strap_t i_rx_boost_strap_a,
  input wire lccr_pkg::lccr_strap_t i_rx_boost_strap_b,
  input wire lccr_pkg::lccr_strap_t i_tx_emphasis_strap_a,
  input wire lccr_pkg::lccr_strap_t i_tx_emphasis_strap_b,
  input wire logic i_signal_presence_detect,
  input wire logic i_rate_detect_high,
  input wire logic [7:0] o_rd_data,
  input wire logic o_rd_valid,
  input wire lccr_pkg::lccr_lane_cfg_t o_cfg
);
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);
  logic hit;
  assign hit = i_addr inside {8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h2B};
  chk_rd_valid_pulse: assert property (i_rd_en |=> o_rd_valid)
    else $error("no read valid pulse");
  chk_no_stray_valid: assert property (!i_rd_en |=> !o_rd_valid)
    else $error("stray read valid");
  chk_rd_data_hold: assert property (!i_rd_en |=> $stable(o_rd_data))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (i_rd_en && !hit |=> o_rd_data == 8'h00)
    else $error("unmapped read not zero");
  chk_eq_readback: assert property (
    i_wr_en && i_addr == 8'h24 ##1 !i_wr_en ##1 i_rd_en && i_addr == 8'h24
    |=> o_rd_data == ($past(i_wr_data, 3) & 8'h3F))
    else $error("equalizer readback wrong");
  chk_auto_mute: assert property (o_cfg.auto_idle |->
    o_cfg.output_mute == !$past(i_signal_presence_detect))
    else $error("auto idle mute wrong");
  chk_auto_rate: assert property (o_cfg.auto_rate |->
    o_cfg.rate_high == $past(i_rate_detect_high))
    else $error("auto rate wrong");
  chk_strap_bypass: assert property (i_pin_mode &&
    i_rx_boost_strap_a == lccr_pkg::STRAP_FLOAT &&
    i_rx_boost_strap_b == lccr_pkg::STRAP_FLOAT |=> {o_cfg.eq_enable,
    o_cfg.gain_stage_field, o_cfg.boost_step_field} == 6'h20)
    else $error("floating eq straps not bypass");
  chk_strap_emph: assert property (i_pin_mode &&
    i_tx_emphasis_strap_b == lccr_pkg::STRAP_LOW &&
    i_tx_emphasis_strap_a == lccr_pkg::STRAP_HIGH |=>
    {o_cfg.emphasis_type, o_cfg.emphasis_level} == 8'h38)
    else $error("emphasis strap code wrong");
endmodule // lccr_regs_sva

/* File: lccr_host.sv */
`timescale 1ns/100ps
module lccr_host (
  input wire logic i_mclk,
  input wire logic i_rd_valid,
  input wire logic [7:0] i_rd_data,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wr_data
);
  initial
  begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wr_data = 8'h00;
  end
  // reserved bits zero
  // callers pass data with reserved positions cleared; idle bus is inverted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    o_wr_en <= 1'b1;
    o_addr <= a;
    o_wr_data <= d;
    @(posedge i_mclk);
    o_wr_en <= 1'b0;
    o_addr <= ~a;
    o_wr_data <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge i_mclk);
    o_rd_en <= 1'b1;
    o_addr <= a;
    @(posedge i_mclk);
    o_rd_en <= 1'b0;
    o_addr <= ~a;
    for (int n = 0; n < 4 && !ok; n++)
    begin
      @(posedge i_mclk);
      if (i_rd_valid === 1'b1)
      begin
        ok = 1'b1;
        d = i_rd_data;
      end
    end
  endtask
endmodule // lccr_host

/* File: lccr_regs_tb.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("ERROR %0t: got %0h exp %0h", $time, g, e); \
  end end
module lccr_regs_tb;
  typedef lccr_pkg::lccr_strap_t lccr_st_t;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic pin = 1'b0;
  logic sd = 1'b0;
  logic rdh = 1'b0;
  lccr_st_t eq_a = lccr_pkg::STRAP_LOW;
  lccr_st_t eq_b = lccr_pkg::STRAP_LOW;
  lccr_st_t em_a = lccr_pkg::STRAP_LOW;
  lccr_st_t em_b = lccr_pkg::STRAP_LOW;
  logic i_wr_en, i_rd_en, o_rd_valid, rok;
  logic [7:0] i_addr, i_wr_data, o_rd_data, rdat, em_now;
  logic [5:0] eq_now;
  lccr_pkg::lccr_lane_cfg_t o_cfg;
  int fail_count = 0;
  int total_checks = 0;
  logic [11:0] eqt [9] = '{12'hA20, 12'h52A, 12'h030, 12'h231, 12'h138,
    12'h634, 12'h435, 12'h83A, 12'h93C};
  logic [11:0] emt [8] = '{12'h001, 12'h138, 12'h288, 12'h490, 12'h6A0,
    12'h890, 12'h9A0, 12'hAC0};
  assign eq_now = {o_cfg.eq_enable, o_cfg.gain_stage_field,
    o_cfg.boost_step_field};
  assign em_now = {o_cfg.emphasis_type, o_cfg.emphasis_level};
  always #12.5 i_mclk = ~i_mclk;
  lccr_host lccr_host_inst (.i_mclk(i_mclk), .i_rd_valid(o_rd_valid),
    .i_rd_data(o_rd_data), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en),
    .o_addr(i_addr), .o_wr_data(i_wr_data));
  lccr_regs lccr_regs_inst (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_pin_mode(pin),
    .i_rx_boost_strap_a(eq_a), .i_rx_boost_strap_b(eq_b),
    .i_tx_emphasis_strap_a(em_a), .i_tx_emphasis_strap_b(em_b),
    .i_signal_presence_detect(sd), .i_rate_detect_high(rdh),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_cfg(o_cfg));
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    lccr_host_inst.rd(a, rdat, rok);
    if (rok !== 1'b1)
    begin
      fail_count++;
      $display("ERROR %0t: read timed out", $time);
      summarize();
    end
    else
      `CHK(rdat, e)
  endtask
  // register writes reach the lane two edges later
  task automatic settle();
    repeat (2) @(posedge i_mclk);
    #1;
  endtask
  task automatic t_reset_values();
    logic [7:0] ra [7] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h2B, 8'h30};
    logic [7:0] rv [7] = '{8'h00, 8'h20, 8'h03, 8'h03, 8'h00, 8'h00, 8'h00};
    settle();
    `CHK(o_cfg, {1'b1, 5'h00, 6'h03, 8'h03, 8'h00})
    for (int i = 0; i < 7; i++)
      rd_chk(ra[i], rv[i]);
  endtask
  task automatic t_fields();
    lccr_host_inst.wr(8'h24, 8'h3A);
    lccr_host_inst.wr(8'h25, 8'h3F);
    lccr_host_inst.wr(8'h26, 8'hA0);
    lccr_host_inst.wr(8'h27, 8'h09);
    lccr_host_inst.wr(8'h28, 8'h55);
    settle();
    `CHK(o_cfg.gain_stage_field, 2'h3)
    `CHK(o_cfg.boost_step_field, 3'h2)
    `CHK(o_cfg.lane_output_swing_field, 6'h3F)
    `CHK(em_now, 8'hA0)
    `CHK({o_cfg.deassert_thr, o_cfg.assert_thr}, 4'h9)
    rd_chk(8'h24, 8'h3A);
    rd_chk(8'h27, 8'h09);
    rd_chk(8'h28, 8'h00);
    lccr_host_inst.wr(8'h24, 8'h15);
    rd_chk(8'h24, 8'h15);
    lccr_host_inst.wr(8'h24, 8'h3A);
  endtask
  task automatic t_idle_rate();
    lccr_host_inst.wr(8'h23, 8'h10);
    settle();
    `CHK(o_cfg.output_mute, 1'b1)
    lccr_host_inst.wr(8'h23, 8'h00);
    settle();
    `CHK(o_cfg.output_mute, 1'b0)
    lccr_host_inst.wr(8'h23, 8'h20);
    settle();
    `CHK(o_cfg.output_mute, 1'b1)
    `CHK(o_cfg.auto_idle, 1'b1)
    @(posedge i_mclk);
    sd <= 1'b1;
    settle();
    `CHK(o_cfg.output_mute, 1'b0)
    lccr_host_inst.wr(8'h23, 8'h01);
    settle();
    `CHK(o_cfg.rate_high, 1'b1)
    @(posedge i_mclk);
    rdh <= 1'b1;
    lccr_host_inst.wr(8'h23, 8'h02);
    settle();
    `CHK(o_cfg.rate_high, 1'b1)
    `CHK(o_cfg.auto_rate, 1'b1)
    @(posedge i_mclk);
    rdh <= 1'b0;
    settle();
    `CHK(o_cfg.rate_high, 1'b0)
  endtask
  task automatic t_straps();
    for (int i = 0; i < 9; i++)
    begin
      @(posedge i_mclk);
      pin <= 1'b1;
      eq_a <= lccr_st_t'(eqt[i][11:10]);
      eq_b <= lccr_st_t'(eqt[i][9:8]);
      em_b <= lccr_st_t'(emt[i % 8][11:10]);
      em_a <= lccr_st_t'(emt[i % 8][9:8]);
      settle();
      `CHK(eq_now, eqt[i][5:0])
      `CHK(em_now, emt[i % 8][7:0])
    end
    @(posedge i_mclk);
    pin <= 1'b0;
    settle();
    `CHK(eq_now, 6'h3A)
  endtask
  // a reset in mid-run must bring every field back to its default
  task automatic t_mid_reset();
    lccr_host_inst.wr(8'h25, 8'h1F);
    lccr_host_inst.wr(8'h2B, 8'h31);
    rd_chk(8'h2B, 8'h31);
    @(posedge i_mclk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_nrst <= 1'b1;
    settle();
    `CHK(o_cfg, {1'b1, 5'h00, 6'h03, 8'h03, 8'h00})
    rd_chk(8'h25, 8'h03);
    rd_chk(8'h24, 8'h20);
    rd_chk(8'h2B, 8'h00);
  endtask
  initial
  begin
    repeat (4) @(posedge i_mclk);
    i_nrst <= 1'b1;
    t_reset_values();
    t_fields();
    t_idle_rate();
    t_straps();
    t_mid_reset();
    summarize();
  end
endmodule // lccr_regs_tb
bind lccr_regs lccr_regs_sva lccr_regs_sva_inst (.i_mclk(i_mclk),
  .i_nrst(i_nrst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr),
  .i_wr_data(i_wr_data), .i_pin_mode(i_pin_mode),
  .i_rx_boost_strap_a(i_rx_boost_strap_a),
  .i_rx_boost_strap_b(i_rx_boost_strap_b),
  .i_tx_emphasis_strap_a(i_tx_emphasis_strap_a),
  .i_tx_emphasis_strap_b(i_tx_emphasis_strap_b),
  .i_signal_presence_detect(i_signal_presence_detect),
  .i_rate_detect_high(i_rate_detect_high), .o_rd_data(o_rd_data),
  .o_rd_valid(o_rd_valid), .o_cfg(o_cfg));
